// ===== hdl/sslc_limreg.sv
// Purpose: One stack word register with the fixed bits forced
// Assumes: Writes come from the core on the same clock
// Notes: Bit 0 reads zero, bits 15..12 read one
module sslc_limreg
   import sslc_pkg::*;
#(
   parameter logic [15:0] RST_VAL = 16'hf000
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_we,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_q
);
   logic [15:0] store;
   wire logic [15:0] next_store = (i_wdata & SSLC_FREE_MASK) | SSLC_FIXED_ONES;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         store <= RST_VAL;
      end else if (i_we) begin
         store <= next_store;
      end
   end

   assign o_q = store;

   a_fixed_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (store[0] == 1'b0) && (store[15:12] == 4'hf))
      else $error("fixed bits of stack word violated");
endmodule : sslc_limreg

// ===== hdl/sslc_pkg.sv
// Purpose: Shared constants for the system stack limit checker
// Assumes: 16-bit special function register words, one core clock
// Notes: Reset values of the three registers are a design choice
package sslc_pkg;
   localparam int unsigned SSLC_W = 16;
   localparam logic [15:0] SSLC_FIXED_ONES = 16'hf000;
   localparam logic [15:0] SSLC_FREE_MASK = 16'h0ffe;
   localparam logic [15:0] SSLC_PTR_RST = 16'hfc00;
   localparam logic [15:0] SSLC_OVL_RST = 16'hfa00;
   localparam logic [15:0] SSLC_UNL_RST = 16'hfc00;
   localparam logic [15:0] SSLC_WORD_STEP = 16'h0002;
   localparam logic [1:0] SSLC_SEL_PTR = 2'h0;
   localparam logic [1:0] SSLC_SEL_OVL = 2'h1;
   localparam logic [1:0] SSLC_SEL_UNL = 2'h2;
   typedef enum logic [1:0] {
      SSLC_CHK_NONE,
      SSLC_CHK_LOW,
      SSLC_CHK_HIGH
   } sslc_chk_t;
endpackage : sslc_pkg

// ===== hdl/sslc_top.sv
// Purpose: System stack pointer with lower and upper limit trap checks
// Assumes: Core may issue several stack operations per cycle; the priority order picks one
// Notes: Traps are one-cycle requests to the trap logic
module sslc_top
   import sslc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic i_add,
   input wire logic i_sub,
   input wire logic [15:0] i_adj,
   input wire logic i_wr,
   input wire logic [1:0] i_wr_sel,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_stack_top_pointer,
   output logic [15:0] o_stack_lower_limit,
   output logic [15:0] o_stack_upper_limit,
   output logic o_ovf_trap,
   output logic o_unf_trap
);
   logic [15:0] ptr;
   logic [15:0] ovl;
   logic [15:0] unl;
   sslc_chk_t chk;
   logic ovf_q;
   logic unf_q;

   // Priority: direct pointer write, then push/sub, then pop/add; limit writes block no operation
   wire logic wr_ptr = i_wr && (i_wr_sel == SSLC_SEL_PTR);
   // Select code 3 reaches no register
   wire logic wr_ovl = i_wr && (i_wr_sel == SSLC_SEL_OVL);
   wire logic wr_unl = i_wr && (i_wr_sel == SSLC_SEL_UNL);
   wire logic go_low = !wr_ptr && (i_push || i_sub);
   wire logic go_high = !wr_ptr && !go_low && (i_pop || i_add);
   // Each direction picks its own step, so a losing op cannot lend its size
   wire logic [15:0] step_low = i_push ? SSLC_WORD_STEP : i_adj;
   wire logic [15:0] step_high = i_pop ? SSLC_WORD_STEP : i_adj;
   wire logic [15:0] moved = go_low ? ptr - step_low : ptr + step_high;
   wire logic ptr_we = wr_ptr || go_low || go_high;
   wire logic [15:0] ptr_in = wr_ptr ? i_wdata : moved;
   wire sslc_chk_t next_chk = go_low ? SSLC_CHK_LOW : (go_high ? SSLC_CHK_HIGH : SSLC_CHK_NONE);
   // Limit writes set no check, so they never trap by themselves
   wire logic next_ovf = (chk == SSLC_CHK_LOW) && (ptr < ovl);
   wire logic next_unf = (chk == SSLC_CHK_HIGH) && (ptr > unl);

   sslc_limreg #(.RST_VAL(SSLC_PTR_RST)) u_ptr (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_we(ptr_we),
      .i_wdata(ptr_in),
      .o_q(ptr)
   );
   sslc_limreg #(.RST_VAL(SSLC_OVL_RST)) u_ovl (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_we(wr_ovl),
      .i_wdata(i_wdata),
      .o_q(ovl)
   );
   sslc_limreg #(.RST_VAL(SSLC_UNL_RST)) u_unl (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_we(wr_unl),
      .i_wdata(i_wdata),
      .o_q(unl)
   );

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         chk <= SSLC_CHK_NONE;
      end else begin
         chk <= next_chk;
      end
   end

   // Compare on the stored pointer: keeps the adder off the compare path
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
      end else begin
         ovf_q <= next_ovf;
         unf_q <= next_unf;
      end
   end

   assign o_stack_top_pointer = ptr;
   assign o_stack_lower_limit = ovl;
   assign o_stack_upper_limit = unl;
   assign o_ovf_trap = ovf_q;
   assign o_unf_trap = unf_q;

   // Pointer movement
   a_push_decrement: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_push && !i_wr)
      |=> (ptr == (($past(ptr) - SSLC_WORD_STEP) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("push did not pre-decrement pointer");

   a_pop_increment: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_pop && !i_push && !i_sub && !i_wr)
      |=> (ptr == (($past(ptr) + SSLC_WORD_STEP) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("pop did not post-increment pointer");

   a_sub_decrement: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sub && !i_push && !i_wr)
      |=> (ptr == (($past(ptr) - $past(i_adj)) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("subtraction did not lower pointer by the amount");

   a_add_increment: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_add && !i_pop && !i_push && !i_sub && !i_wr)
      |=> (ptr == (($past(ptr) + $past(i_adj)) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("addition did not raise pointer by the amount");

   a_idle_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!i_push && !i_pop && !i_add && !i_sub && !wr_ptr)
      |=> $stable(ptr))
      else $error("pointer moved without an operation");

   a_write_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ptr
      |=> (ptr == ($past(i_wdata) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("pointer write not stored with fixed bits");

   // Trap decisions, one cycle after the stored pointer
   a_overflow_trap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      go_low ##1 (ptr < ovl)
      |=> o_ovf_trap)
      else $error("overflow trap missing");

   a_no_ovf_inside: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      go_low ##1 (ptr >= ovl)
      |=> !o_ovf_trap)
      else $error("overflow trap with pointer inside lower limit");

   a_ovf_needs_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (chk != SSLC_CHK_LOW)
      |=> !o_ovf_trap)
      else $error("overflow trap without a downward check");

   a_underflow_trap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      go_high ##1 (ptr > unl)
      |=> o_unf_trap)
      else $error("underflow trap missing");

   a_no_unf_inside: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      go_high ##1 (ptr <= unl)
      |=> !o_unf_trap)
      else $error("underflow trap with pointer inside upper limit");

   a_unf_needs_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (chk != SSLC_CHK_HIGH)
      |=> !o_unf_trap)
      else $error("underflow trap without an upward check");

   a_move_no_trap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ptr
      |-> ##2 (!o_ovf_trap && !o_unf_trap))
      else $error("direct pointer write caused a trap");

   a_write_drops_op: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_ptr && (i_push || i_pop || i_add || i_sub))
      |=> (chk == SSLC_CHK_NONE))
      else $error("stack operation checked beside a pointer write");

   a_limit_no_trap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_wr && !i_push && !i_pop && !i_add && !i_sub)
      |-> ##2 (!o_ovf_trap && !o_unf_trap))
      else $error("limit write caused a trap");

   a_traps_exclusive: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_ovf_trap
      |-> !o_unf_trap)
      else $error("both traps raised together");

   a_trap_cause: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_ovf_trap
      |-> $past(go_low, 2))
      else $error("overflow trap without a push two cycles earlier");

   a_unf_cause: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_unf_trap
      |-> $past(go_high, 2))
      else $error("underflow trap without a pop two cycles earlier");

   // Limit registers
   a_ovl_store: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_ovl
      |=> (ovl == ($past(i_wdata) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("lower limit write not stored with fixed bits");

   a_unl_store: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      wr_unl
      |=> (unl == ($past(i_wdata) & SSLC_FREE_MASK | SSLC_FIXED_ONES)))
      else $error("upper limit write not stored with fixed bits");

   a_limits_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!wr_ovl && !wr_unl)
      |=> ($stable(ovl) && $stable(unl)))
      else $error("limit changed without its own write");

   a_limit_fixed: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (ovl[0] == 1'b0) && (ovl[15:12] == 4'hf)
      && (unl[0] == 1'b0) && (unl[15:12] == 4'hf))
      else $error("limit fixed bits violated");

   // Scenario covers
   c_push: cover property (@(posedge i_sys_clk) disable iff (i_rst) i_push);
   c_ovf: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_ovf_trap);
   c_unf: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_unf_trap);
   c_move_out: cover property (@(posedge i_sys_clk) disable iff (i_rst) wr_ptr ##1 (ptr < ovl));
   c_write_wins: cover property (@(posedge i_sys_clk) disable iff (i_rst) wr_ptr && (i_push || i_sub));
endmodule : sslc_top

// ===== tb/sslc_top_tb_top.sv
// Purpose: Self-checking bench for the stack limit checker
// Assumes: Inputs change on the falling edge
// Notes: Trap counts come from the trap model
module sslc_top_tb_top
   import sslc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, push = 0, pop = 0, add = 0, sub = 0, wr = 0;
   logic [1:0] sel = 2'h0;
   logic [15:0] d = 16'h0000;
   wire logic [15:0] sp, lo, hi;
   wire logic ovf, unf;
   int novf, nunf, errors = 0, tests_run = 0;
   always #25 clk = ~clk;
   sslc_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_push(push), .i_pop(pop), .i_add(add), .i_sub(sub),
      .i_adj(d), .i_wr(wr), .i_wr_sel(sel), .i_wdata(d), .o_stack_top_pointer(sp),
      .o_stack_lower_limit(lo), .o_stack_upper_limit(hi), .o_ovf_trap(ovf), .o_unf_trap(unf));
   sslc_trap_model model_u (.i_sys_clk(clk), .i_rst(rst), .i_ovf(ovf), .i_unf(unf), .o_novf(novf),
      .o_nunf(nunf));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Op bits: push, pop, add, sub, write
   task drv(input logic [4:0] k, input logic [1:0] s, input logic [15:0] v);
      @(negedge clk);
      {push, pop, add, sub, wr} = k;
      sel = s;
      d = v;
      @(negedge clk);
      {push, pop, add, sub, wr} = 5'h00;
   endtask : drv
   task trap(input int eo, input int eu);
      repeat (2) @(negedge clk);
      chk("ovf_count", 16'(novf), 16'(eo));
      chk("unf_count", 16'(nunf), 16'(eu));
   endtask : trap
   task s_reset;
      chk("sp", sp, SSLC_PTR_RST);
      chk("lo", lo, SSLC_OVL_RST);
      chk("hi", hi, SSLC_UNL_RST);
      trap(0, 0);
   endtask : s_reset
   task s_write;
      drv(5'h01, SSLC_SEL_PTR, 16'h0123);
      chk("sp", sp, 16'hf122);
      drv(5'h01, SSLC_SEL_OVL, 16'h0fff);
      chk("lo", lo, 16'hfffe);
      drv(5'h01, SSLC_SEL_UNL, 16'h0001);
      chk("hi", hi, 16'hf000);
      trap(0, 0);
   endtask : s_write
   task s_push;
      // Pointer sits two bytes above the lower limit, room for one push
      drv(5'h01, SSLC_SEL_OVL, 16'hfa00);
      drv(5'h01, SSLC_SEL_UNL, 16'hfc00);
      drv(5'h01, SSLC_SEL_PTR, 16'hfa02);
      drv(5'h10, 2'h0, 16'h0000);
      chk("sp", sp, 16'hfa00);
      trap(0, 0);
      drv(5'h10, 2'h0, 16'h0000);
      chk("sp", sp, 16'hf9fe);
      trap(1, 0);
   endtask : s_push
   task s_pop;
      drv(5'h01, SSLC_SEL_PTR, 16'hfbfe);
      drv(5'h00, 2'h0, 16'h0000);
      drv(5'h08, 2'h0, 16'h0000);
      chk("sp", sp, 16'hfc00);
      trap(1, 0);
      drv(5'h08, 2'h0, 16'h0000);
      chk("sp", sp, 16'hfc02);
      trap(1, 1);
   endtask : s_pop
   task s_adj;
      drv(5'h02, 2'h0, 16'h0204);
      chk("sp", sp, 16'hf9fe);
      trap(2, 1);
      drv(5'h04, 2'h0, 16'h0206);
      chk("sp", sp, 16'hfc04);
      trap(2, 2);
   endtask : s_adj
   task s_prio;
      // Write beats push: pointer lands below the limit with no trap
      drv(5'h11, SSLC_SEL_PTR, 16'hf800);
      chk("sp", sp, 16'hf800);
      trap(2, 2);
      drv(5'h00, 2'h0, 16'h0000);
      // Sub beats pop and must use its own amount
      drv(5'h0a, 2'h0, 16'h0100);
      chk("sp", sp, 16'hf700);
      trap(3, 2);
      drv(5'h01, 2'h3, 16'h0abc);
      chk("sp", sp, 16'hf700);
      chk("lo", lo, 16'hfa00);
      chk("hi", hi, 16'hfc00);
      drv(5'h14, 2'h0, 16'h0100);
      chk("sp", sp, 16'hf6fe);
      trap(4, 2);
   endtask : s_prio
   task conclude;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // Run is short; this only guards against a hang
   initial begin
      #100000;
      errors++;
      conclude();
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      s_reset();
      s_write();
      s_push();
      s_pop();
      s_adj();
      s_prio();
      conclude();
   end
endmodule : sslc_top_tb_top

// ===== tb/sslc_trap_model.sv
// Purpose: Trap logic stand-in that counts stack trap requests
// Assumes: Requests are one-cycle pulses on the core clock
// Notes: Counting per cycle exposes over-long pulses
module sslc_trap_model (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_ovf,
   input wire logic i_unf,
   output int o_novf,
   output int o_nunf
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_novf <= 0;
         o_nunf <= 0;
      end else begin
         o_novf <= o_novf + int'(i_ovf === 1'b1);
         o_nunf <= o_nunf + int'(i_unf === 1'b1);
      end
   end
endmodule : sslc_trap_model
